// [common/eu_cfg.svh]
// Constants for the fraction, indexed jump and halt execution logic
`ifndef EU_CFG_SVH
`define EU_CFG_SVH

// Channel count and word widths
`define EU_LANES 16
`define EU_WORD_W 32
`define EU_OPC_W 7
`define EU_HALF_W 16

// Opcodes handled by this unit
`define OPC_FRC 7'h43
`define OPC_JUMP_INDEXED 7'h20
`define OPC_HALT 7'h2a

// Instruction length in 64-bit units
`define IP_STEP_COMPACT 32'h0000_0001
`define IP_STEP_FULL 32'h0000_0002

// Halt operand fields
`define HALT_CHAN_MSB 31
`define HALT_CHAN_LSB 16
`define HALT_INSTR_MSB 15
`define HALT_INSTR_LSB 0

// Reset values
`define RST_IP 32'h0000_0000
`define RST_ACTIVE_MASK 16'hffff

// Single precision float constants
`define FP_EXP_SPECIAL 8'hff
`define FP_EXP_ZERO 8'h00
`define FP_EXP_BIAS 8'h7f
`define FP_EXP_INT 8'h96
`define FP_EXP_TINY 8'h67
`define FP_SHIFT_BASE 8'h66
`define FP_NORM_BASE 8'h4f
`define FP_POS_ZERO 32'h0000_0000
`define FP_QNAN 32'h7fc0_0000
`define FP_BELOW_ONE 32'h3f7f_ffff
`define FP_FIX_W 48
`define FP_MSB_W 6
`define FP_FIX_TOP 6'h2f

`endif

// [common/eu_pkg.sv]
// Types shared by the execution control logic
package eu_pkg;
`include "eu_cfg.svh"

    typedef logic [`EU_LANES-1:0][`EU_WORD_W-1:0] lanes_t;
    typedef logic [`EU_LANES-1:0] lane_mask_t;

    typedef struct packed {
        logic [`EU_OPC_W-1:0] opcode;
        logic compacted;
        logic predicated;
        logic pred_ch0;
        logic no_mask_option;
        lane_mask_t write_enable_mask;
        logic single_program_flow;
        logic alt_mode;
        logic saturate;
        logic acc_update;
        logic [`EU_WORD_W-1:0] src1;
        lanes_t src0;
    } issue_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_SWITCH = 2'b10
    } exec_state_t;

    typedef struct packed {
        exec_state_t state;
        logic [`EU_WORD_W-1:0] ip;
        lanes_t per_channel_ip;
        lane_mask_t active_channel_mask;
        lanes_t dst;
        lane_mask_t dst_we;
        logic acc_we;
        logic done;
        logic jump_taken;
        logic thread_switch;
    } ctrl_t;

endpackage : eu_pkg

// [design/frc_lane.sv]
// One channel of the floating point fraction operation
`include "eu_cfg.svh"
module frc_lane
    import eu_pkg::*;
(
    input wire logic [`EU_WORD_W-1:0] src_in,
    input wire logic alt_mode_in,
    output logic [`EU_WORD_W-1:0] res_out
);

    function automatic logic [`FP_MSB_W-1:0] find_msb(input logic [`FP_FIX_W-1:0] v);
        logic [`FP_MSB_W-1:0] p;
        p = '0;
        for (int i = 0; i < `FP_FIX_W; i++) begin
            if (v[i]) begin
                p = `FP_MSB_W'(i);
            end
        end
        return p;
    endfunction : find_msb

    logic sign;
    logic [7:0] expo;
    logic [23:0] mant;
    logic [71:0] wide;
    logic [`FP_FIX_W-1:0] fx;
    logic [`FP_FIX_W-1:0] g;
    logic [`FP_FIX_W-1:0] norm;
    logic [`FP_MSB_W-1:0] lead;

    always_comb begin
        sign = src_in[31];
        expo = src_in[30:23];
        mant = {1'b1, src_in[22:0]};
        wide = '0;
        fx = '0;
        g = '0;
        norm = '0;
        lead = '0;
        res_out = `FP_POS_ZERO;
        if (expo == `FP_EXP_SPECIAL) begin
            // Largest-magnitude codes are integers in the alternate mode
            res_out = alt_mode_in ? `FP_POS_ZERO : `FP_QNAN;
        end else if (expo == `FP_EXP_ZERO) begin
            res_out = `FP_POS_ZERO;
        end else if (expo >= `FP_EXP_INT) begin
            res_out = `FP_POS_ZERO;
        end else if (!sign && expo < `FP_EXP_BIAS) begin
            res_out = src_in;
        end else if (sign && expo < `FP_EXP_TINY) begin
            // Truncation keeps one minus a tiny value strictly below one
            res_out = `FP_BELOW_ONE;
        end else begin
            wide = {48'h0, mant} << (expo - `FP_SHIFT_BASE);
            fx = wide[`FP_FIX_W-1:0];
            g = sign ? (`FP_FIX_W'(0) - fx) : fx;
            lead = find_msb(g);
            norm = g << (`FP_FIX_TOP - lead);
            if (fx != '0) begin
                res_out = {1'b0, `FP_NORM_BASE + 8'(lead), norm[46:24]};
            end
        end
    end

endmodule : frc_lane

// [design/eu_fraction_and_jump_control.sv]
// Execution control for the fraction, indexed jump and halt instructions
`include "eu_cfg.svh"
// Function
// - fraction writes source minus floor into each enabled channel, result 0 to 1.
// - IEEE mode: inf or NaN gives NaN; zeros, denormals give +0; else [+0,1).
// - ALT mode: max magnitude, zeros, denormals give +0; finite gives [+0,1).
// - Saturation has no effect on the fraction result.
// - With implicit accumulator update, accumulator is written with undefined data.
// - Halt operand: channel offset bits 31:16, instruction offset 15:0, signed, pre-increment.
// - Halt with single program flow keeps channel pointers, jumps by channel offset.
// - Indexed jump 0x20 moves by signed index from the post-incremented pointer.
// - Index signed; 0 continues to next instruction, -1 loops forever for a compacted jump.
// - Only the low 16 bits of the jump operand count; range -32768 to 32767.
// - Indexed jump executes whatever the write enable mask; no-mask option set.
// - After an indexed jump a thread switch resolves masks and pointer.
// - Predicated jump is taken only when predicate channel zero is true.
// - Jump target adds one for compacted, two for full-length instructions.
// - With single program flow an indexed jump leaves channel pointers alone.
// - Halt sets enabled channel pointers to IP plus offset, others to next.
// - Halt clears enabled active mask bits; jump when the mask becomes zero.
module eu_fraction_and_jump_control
    import eu_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic issue_valid_in,
    input wire issue_t issue_in,
    output logic issue_ready_out,
    input wire logic load_valid_in,
    input wire logic [`EU_WORD_W-1:0] load_ip_in,
    input wire lane_mask_t load_active_mask_in,
    output logic [`EU_WORD_W-1:0] exec_ip_out,
    output lanes_t per_channel_ip_out,
    output lane_mask_t active_channel_mask_out,
    output lanes_t dst_out,
    output lane_mask_t dst_we_out,
    output logic acc_we_out,
    output logic done_out,
    output logic jump_taken_out,
    output logic thread_switch_out
);

    // Length of the issuing instruction in 64-bit units
    function automatic logic [`EU_WORD_W-1:0] instr_step(input logic compacted);
        return compacted ? `IP_STEP_COMPACT : `IP_STEP_FULL;
    endfunction : instr_step

    // Signed 16-bit offset widened to pointer width
    function automatic logic [`EU_WORD_W-1:0] sext16(input logic [`EU_HALF_W-1:0] v);
        return {{(`EU_WORD_W-`EU_HALF_W){v[`EU_HALF_W-1]}}, v};
    endfunction : sext16

    ctrl_t cur_q;
    ctrl_t cur_d;
    lanes_t frc_res;

    logic take;
    logic [`EU_WORD_W-1:0] ip_next;
    logic [`EU_WORD_W-1:0] jump_target;
    logic [`EU_WORD_W-1:0] halt_instr_target;
    logic [`EU_WORD_W-1:0] halt_chan_target;
    lane_mask_t halt_mask;
    logic halt_all_moved;

    for (genvar n = 0; n < `EU_LANES; n++) begin : g_lane
        frc_lane u_frc (
            .src_in(issue_in.src0[n]),
            .alt_mode_in(issue_in.alt_mode),
            .res_out(frc_res[n])
        );
    end

    // One cycle of refusal after a jump stands in for the thread switch
    assign issue_ready_out = (cur_q.state == ST_RUN) && !load_valid_in;
    assign take = issue_valid_in && issue_ready_out;

    always_comb begin
        cur_d = cur_q;
        cur_d.done = 1'b0;
        cur_d.jump_taken = 1'b0;
        cur_d.thread_switch = 1'b0;
        cur_d.dst_we = '0;
        cur_d.acc_we = 1'b0;

        ip_next = cur_q.ip + instr_step(issue_in.compacted);
        // Jump index uses only its low half, taken from the second source
        jump_target = ip_next
            + sext16(issue_in.src1[`EU_HALF_W-1:0]);
        halt_instr_target = cur_q.ip
            + sext16(issue_in.src1[`HALT_INSTR_MSB:`HALT_INSTR_LSB]);
        halt_chan_target = cur_q.ip
            + sext16(issue_in.src1[`HALT_CHAN_MSB:`HALT_CHAN_LSB]);
        halt_mask = cur_q.active_channel_mask & ~issue_in.write_enable_mask;
        halt_all_moved = &issue_in.write_enable_mask;

        case (cur_q.state)
            ST_RUN: begin
                if (load_valid_in) begin
                    cur_d.ip = load_ip_in;
                    cur_d.active_channel_mask = load_active_mask_in;
                    for (int n = 0; n < `EU_LANES; n++) begin
                        cur_d.per_channel_ip[n] = load_ip_in;
                    end
                end else if (take) begin
                    cur_d.done = 1'b1;
                    cur_d.ip = ip_next;
                    case (issue_in.opcode)
                        `OPC_FRC: begin
                            // Saturation is ignored on purpose
                            cur_d.dst_we = issue_in.write_enable_mask;
                            for (int n = 0; n < `EU_LANES; n++) begin
                                if (issue_in.write_enable_mask[n]) begin
                                    cur_d.dst[n] = frc_res[n];
                                end
                            end
                            // Only the accumulator write strobe is driven; its data is not to be relied on
                            cur_d.acc_we = issue_in.acc_update;
                        end
                        `OPC_JUMP_INDEXED: begin
                            // Write enable mask is not consulted here
                            cur_d.state = ST_SWITCH;
                            cur_d.thread_switch = 1'b1;
                            if (!issue_in.predicated || issue_in.pred_ch0) begin
                                cur_d.ip = jump_target;
                                cur_d.jump_taken = 1'b1;
                            end
                            if (!issue_in.single_program_flow) begin
                                for (int n = 0; n < `EU_LANES; n++) begin
                                    cur_d.per_channel_ip[n] = cur_d.ip;
                                end
                            end
                        end
                        `OPC_HALT: begin
                            cur_d.active_channel_mask = halt_mask;
                            if (issue_in.single_program_flow) begin
                                // Channel pointers stay, instruction offset unused
                                if (halt_mask == '0 || halt_all_moved) begin
                                    cur_d.ip = halt_chan_target;
                                    cur_d.jump_taken = 1'b1;
                                end
                            end else begin
                                for (int n = 0; n < `EU_LANES; n++) begin
                                    cur_d.per_channel_ip[n] = issue_in.write_enable_mask[n]
                                        ? halt_instr_target : ip_next;
                                end
                                if (halt_mask == '0 || halt_all_moved) begin
                                    cur_d.ip = halt_instr_target;
                                    cur_d.jump_taken = 1'b1;
                                end
                            end
                        end
                        default: begin
                            cur_d.ip = ip_next;
                        end
                    endcase
                end
            end
            ST_SWITCH: begin
                cur_d.state = ST_RUN;
            end
            default: begin
                cur_d.state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cur_q.state <= ST_RUN;
            cur_q.ip <= `RST_IP;
            cur_q.per_channel_ip <= '0;
            cur_q.active_channel_mask <= `RST_ACTIVE_MASK;
            cur_q.dst <= '0;
            cur_q.dst_we <= '0;
            cur_q.acc_we <= 1'b0;
            cur_q.done <= 1'b0;
            cur_q.jump_taken <= 1'b0;
            cur_q.thread_switch <= 1'b0;
        end else begin
            cur_q <= cur_d;
        end
    end

    assign exec_ip_out = cur_q.ip;
    assign per_channel_ip_out = cur_q.per_channel_ip;
    assign active_channel_mask_out = cur_q.active_channel_mask;
    assign dst_out = cur_q.dst;
    assign dst_we_out = cur_q.dst_we;
    assign acc_we_out = cur_q.acc_we;
    assign done_out = cur_q.done;
    assign jump_taken_out = cur_q.jump_taken;
    assign thread_switch_out = cur_q.thread_switch;

endmodule : eu_fraction_and_jump_control

// [sim/eu_fraction_and_jump_control_chk.sv]
// Assertion checker for the fraction, indexed jump and halt control
`include "eu_cfg.svh"
module eu_fraction_and_jump_control_chk
    import eu_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic issue_valid_in,
    input wire issue_t issue_in,
    input wire logic issue_ready_out,
    input wire logic [`EU_WORD_W-1:0] exec_ip_out,
    input wire lanes_t per_channel_ip_out,
    input wire lane_mask_t active_channel_mask_out,
    input wire lane_mask_t dst_we_out,
    input wire logic acc_we_out,
    input wire logic done_out,
    input wire logic jump_taken_out,
    input wire logic thread_switch_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    logic take, is_frc, is_jmp, is_halt, go, single_flow;
    logic [31:0] step, nxt, jmp_tgt, halt_tgt, lane0_tgt;
    lane_mask_t new_mask;
    assign take = issue_valid_in && issue_ready_out;
    assign is_frc = take && issue_in.opcode == `OPC_FRC;
    assign is_jmp = take && issue_in.opcode == `OPC_JUMP_INDEXED;
    assign is_halt = take && issue_in.opcode == `OPC_HALT;
    assign go = !issue_in.predicated || issue_in.pred_ch0;
    assign single_flow = issue_in.single_program_flow;
    assign step = issue_in.compacted ? `IP_STEP_COMPACT : `IP_STEP_FULL;
    assign nxt = exec_ip_out + step;
    assign jmp_tgt = nxt + {{16{issue_in.src1[15]}}, issue_in.src1[15:0]};
    // Channel offset when single flow is on, else instruction offset
    assign halt_tgt = exec_ip_out + (single_flow ? {{16{issue_in.src1[31]}}, issue_in.src1[31:16]}
                                                 : {{16{issue_in.src1[15]}}, issue_in.src1[15:0]});
    assign lane0_tgt = issue_in.write_enable_mask[0] ? halt_tgt : nxt;
    assign new_mask = active_channel_mask_out & ~issue_in.write_enable_mask;

    AST_JMP_TARGET: assert property (is_jmp && go |=> exec_ip_out == $past(jmp_tgt))
        else $error("jump target wrong");
    AST_JMP_PRED_OFF: assert property (is_jmp && !go |=>
        exec_ip_out == $past(nxt) && !jump_taken_out) else $error("jump taken on false pred");
    AST_JMP_SWITCH: assert property (is_jmp |=> thread_switch_out && !issue_ready_out)
        else $error("no thread switch after jump");
    AST_JMP_SINGLE_FLOW: assert property (is_jmp && single_flow |=>
        $stable(per_channel_ip_out)) else $error("jump moved channel pointers");
    AST_HALT_MASK: assert property (is_halt |=>
        active_channel_mask_out == $past(new_mask)) else $error("halt mask wrong");
    AST_HALT_JUMP: assert property (is_halt && new_mask == 16'h0 |=>
        exec_ip_out == $past(halt_tgt) && jump_taken_out) else $error("halt jump wrong");
    AST_HALT_SINGLE_FLOW: assert property (is_halt && single_flow |=>
        $stable(per_channel_ip_out) && done_out) else $error("halt moved channel pointers");
    AST_HALT_CHAN_IP: assert property (is_halt && !single_flow |=>
        per_channel_ip_out[0] == $past(lane0_tgt)) else $error("halt lane pointer wrong");
    AST_FRC_STROBE: assert property (is_frc |=>
        dst_we_out == $past(issue_in.write_enable_mask) && done_out) else $error("frc strobe");
    AST_FRC_ACC: assert property (is_frc |=> acc_we_out == $past(issue_in.acc_update))
        else $error("frc accumulator strobe");
    COV_JMP: cover property (is_jmp && go);
    COV_HALT_JUMP: cover property (is_halt && new_mask == 16'h0);
    COV_FRC: cover property (is_frc);
endmodule : eu_fraction_and_jump_control_chk

bind eu_fraction_and_jump_control eu_fraction_and_jump_control_chk
    i_eu_fraction_and_jump_control_chk (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .issue_valid_in(issue_valid_in),
    .issue_in(issue_in), .issue_ready_out(issue_ready_out), .exec_ip_out(exec_ip_out),
    .per_channel_ip_out(per_channel_ip_out), .active_channel_mask_out(active_channel_mask_out),
    .dst_we_out(dst_we_out), .acc_we_out(acc_we_out), .done_out(done_out),
    .jump_taken_out(jump_taken_out), .thread_switch_out(thread_switch_out));

// [sim/eu_fraction_and_jump_control_tb_top.sv]
// Self-checking testbench for the fraction, indexed jump and halt control
`include "eu_cfg.svh"
module eu_fraction_and_jump_control_tb_top import eu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in, sys_rst_in, issue_valid_in, load_valid_in, issue_ready_out;
    logic acc_we_out, done_out, jump_taken_out, thread_switch_out;
    issue_t issue_in, iss;
    logic [31:0] load_ip_in, exec_ip_out, pc_exp;
    lane_mask_t load_active_mask_in, active_channel_mask_out, dst_we_out;
    lanes_t per_channel_ip_out, dst_out;
    int errors, total_checks;

    eu_fraction_and_jump_control i_eu_fraction_and_jump_control (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .issue_valid_in(issue_valid_in),
        .issue_in(issue_in), .issue_ready_out(issue_ready_out), .load_valid_in(load_valid_in),
        .load_ip_in(load_ip_in), .load_active_mask_in(load_active_mask_in),
        .exec_ip_out(exec_ip_out),
        .per_channel_ip_out(per_channel_ip_out), .active_channel_mask_out(active_channel_mask_out),
        .dst_out(dst_out), .dst_we_out(dst_we_out), .acc_we_out(acc_we_out), .done_out(done_out),
        .jump_taken_out(jump_taken_out), .thread_switch_out(thread_switch_out));

    initial begin
        clk_in = 1'h0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic load(input logic [31:0] ip, input lane_mask_t m);
        @(negedge clk_in);
        load_ip_in = ip;
        load_active_mask_in = m;
        load_valid_in = 1'h1;
        @(negedge clk_in);
        load_valid_in = 1'h0;
        pc_exp = ip;
    endtask : load

    task automatic set(input logic [6:0] op, input lane_mask_t we, input logic [31:0] s1,
                       input logic comp, input logic single_flow);
        iss = '0;
        iss.opcode = op;
        iss.write_enable_mask = we;
        iss.src1 = s1;
        iss.compacted = comp;
        iss.single_program_flow = single_flow;
    endtask : set

    // Holds the request until ready is seen, then leaves results for the caller
    task automatic fire();
        int n;
        @(negedge clk_in);
        issue_in = iss;
        issue_valid_in = 1'h1;
        n = 0;
        while (issue_ready_out !== 1'h1 && n < 20) begin
            @(negedge clk_in);
            n++;
        end
        if (n == 20) errors++;
        @(negedge clk_in);
        issue_valid_in = 1'h0;
    endtask : fire

    task automatic test_frc();
        logic [31:0] s [6] = '{32'h4050_0000, 32'hbfe0_0000, 32'h7f80_0000, 32'h8000_0000,
                               32'h0000_0001, 32'h7fc0_0001};
        logic [31:0] e [6] = '{32'h3e80_0000, 32'h3e80_0000, 32'h7fc0_0000, 32'h0000_0000,
                               32'h0000_0000, 32'h7fc0_0000};
        load(32'h0000_0100, 16'hffff);
        // Float sources only, no accumulator operand
        set(`OPC_FRC, 16'h003f, 32'h0, 1'h0, 1'h0);
        iss.saturate = 1'h1;
        iss.acc_update = 1'h1;
        for (int i = 0; i < 6; i++) iss.src0[i] = s[i];
        iss.src0[8] = 32'h4050_0000;
        fire();
        for (int i = 0; i < 6; i++) chk(dst_out[i], e[i]);
        chk(dst_out[8], 32'h0);
        chk(dst_we_out, 16'h003f);
        chk(acc_we_out, 1'h1);
        chk(exec_ip_out, 32'h0000_0102);
        set(`OPC_FRC, 16'h0007, 32'h0, 1'h1, 1'h0);
        iss.alt_mode = 1'h1;
        iss.src0[0] = 32'h7f7f_ffff;
        iss.src0[1] = 32'hff7f_ffff;
        iss.src0[2] = 32'h3fc0_0000;
        fire();
        chk(dst_out[0], 32'h0);
        chk(dst_out[1], 32'h0);
        chk(dst_out[2], 32'h3f00_0000);
        $display("test_frc finished");
    endtask : test_frc

    task automatic jmp(input logic [31:0] s1, input logic comp, input logic pred,
                       input logic pch, input logic single_flow, input logic [31:0] exp_ip);
        // Execution size one, pointer register in both leading operands
        set(`OPC_JUMP_INDEXED, 16'h0000, s1, comp, single_flow);
        iss.no_mask_option = 1'h1;
        iss.predicated = pred;
        iss.pred_ch0 = pch;
        fire();
        if (!single_flow) pc_exp = exp_ip;
        chk(exec_ip_out, exp_ip);
        chk(jump_taken_out, !pred || pch);
        chk(thread_switch_out, 1'h1);
        chk(issue_ready_out, 1'h0);
        chk(per_channel_ip_out[0], pc_exp);
        @(negedge clk_in);
        chk(issue_ready_out, 1'h1);
    endtask : jmp

    task automatic test_jmp();
        load(32'h0001_0000, 16'hffff);
        jmp(32'hffff_0005, 1'h1, 1'h0, 1'h0, 1'h0, 32'h0001_0006);
        jmp(32'h0000_ffff, 1'h1, 1'h0, 1'h0, 1'h0, 32'h0001_0006);
        jmp(32'h0000_0000, 1'h0, 1'h0, 1'h0, 1'h0, 32'h0001_0008);
        jmp(32'h0000_8000, 1'h1, 1'h0, 1'h0, 1'h0, 32'h0000_8009);
        jmp(32'h0000_0010, 1'h0, 1'h1, 1'h0, 1'h0, 32'h0000_800b);
        jmp(32'h0000_0010, 1'h1, 1'h1, 1'h1, 1'h1, 32'h0000_801c);
        $display("test_jmp finished");
    endtask : test_jmp

    task automatic test_halt();
        load(32'h0000_0300, 16'hffff);
        // Halt inside a block: offsets differ, null destination and source
        set(`OPC_HALT, 16'h00ff, 32'h0010_0004, 1'h0, 1'h0);
        fire();
        chk(active_channel_mask_out, 16'hff00);
        chk(per_channel_ip_out[0], 32'h0000_0304);
        chk(per_channel_ip_out[15], 32'h0000_0302);
        chk(exec_ip_out, 32'h0000_0302);
        set(`OPC_HALT, 16'hff00, 32'h0010_fffe, 1'h1, 1'h0);
        fire();
        chk(active_channel_mask_out, 16'h0000);
        chk(exec_ip_out, 32'h0000_0300);
        chk(per_channel_ip_out[0], 32'h0000_0303);
        chk(per_channel_ip_out[15], 32'h0000_0300);
        load(32'h0000_0400, 16'h000f);
        set(`OPC_HALT, 16'h000f, 32'h0020_0008, 1'h1, 1'h1);
        fire();
        chk(exec_ip_out, 32'h0000_0420);
        chk(per_channel_ip_out[15], 32'h0000_0400);
        // Unhandled opcode only steps the pointer
        set(7'h01, 16'hffff, 32'h0000_0040, 1'h0, 1'h0);
        fire();
        chk(exec_ip_out, 32'h0000_0422);
        chk(done_out, 1'h1);
        chk(jump_taken_out, 1'h0);
        chk(dst_we_out, 16'h0000);
        chk(active_channel_mask_out, 16'h0000);
        chk(per_channel_ip_out[15], 32'h0000_0400);
        $display("test_halt finished");
    endtask : test_halt

    task automatic test_reset();
        @(negedge clk_in);
        sys_rst_in = 1'h1;
        @(negedge clk_in);
        chk(exec_ip_out, 32'h0);
        chk(active_channel_mask_out, 16'hffff);
        chk(dst_out[2], 32'h0);
        chk(per_channel_ip_out[15], 32'h0);
        sys_rst_in = 1'h0;
        $display("test_reset finished");
    endtask : test_reset

    task automatic summarize();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // Run takes about 45 cycles, so 20 us means a hang
    initial begin
        #20000;
        errors++;
        summarize();
    end

    initial begin
        sys_rst_in = 1'h1;
        issue_valid_in = 1'h0;
        load_valid_in = 1'h0;
        issue_in = '0;
        iss = '0;
        load_ip_in = 32'h0;
        load_active_mask_in = 16'h0;
        errors = 0;
        total_checks = 0;
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        sys_rst_in = 1'h0;
        test_frc();
        test_jmp();
        test_halt();
        test_reset();
        summarize();
    end
endmodule : eu_fraction_and_jump_control_tb_top
